// ===== test_timer_software_event_generation.sv
// self-checking bench for the timer software event generation block
`timescale 1ns/1ns
module test_timer_software_event_generation
    import tseg_pkg::*;
;
    logic        aclk, aresetn;  // 50 MHz clock, sync reset active low
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    tseg_evt_t   forced_evt;     // one-cycle event pulses
    logic        irq;            // level interrupt
    tseg_evt_t   last_evt;       // events seen during the last write
    int          bad_count;
    int          n_checks;
    // table row
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0]  resp;
    } tseg_row_t;
    tseg_row_t   rows [6];
    logic [7:0]  ctl [5];        // control modes for forced update

    tseg_top #(.CW(16)) dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .forced_evt, .irq
    );

    // free-running clock
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({31'h0, got}, {31'h0, exp});
    endtask

    // write: aw and w offered together, each dropped once taken
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        last_evt = '0;
        @(posedge aclk);
        s_axi_awaddr  <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata   <= data;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            #1;
            aw_hs    = s_axi_awvalid && s_axi_awready;
            w_hs     = s_axi_wvalid && s_axi_wready;
            b_hs     = s_axi_bvalid && s_axi_bready;
            resp     = s_axi_bresp;
            last_evt = last_evt | forced_evt;
            @(posedge aclk);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            if (b_hs) s_axi_bready <= 1'b0;
        end
        while (!b_hs);
    endtask

    // read: arvalid held until taken
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        logic ar_hs;
        logic r_hs;
        @(posedge aclk);
        s_axi_araddr  <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            #1;
            ar_hs = s_axi_arvalid && s_axi_arready;
            r_hs  = s_axi_rvalid && s_axi_rready;
            data  = s_axi_rdata;
            resp  = s_axi_rresp;
            @(posedge aclk);
            if (ar_hs) s_axi_arvalid <= 1'b0;
            if (r_hs) s_axi_rready <= 1'b0;
        end
        while (!r_hs);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [1:0] resp;
        axi_write(addr, data, resp);
        check_word(32'(resp), 32'(TSEG_RESP_OKAY));
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] data;
        logic [1:0]  resp;
        axi_read(addr, data, resp);
        check_word(data, exp);
    endtask

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog
    initial
    begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test();
    end

    initial
    begin
        logic [1:0] resp;
        bad_count = 0;
        n_checks = 0;
        aresetn = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hF;
        rows[0] = '{TSEG_OFF_CMR1, 32'hFFFF_1234, 32'h0000_1234, TSEG_RESP_OKAY};
        rows[1] = '{TSEG_OFF_EGR, 32'hFFFF_FF80, 32'h0000_0000, TSEG_RESP_OKAY};
        rows[2] = '{TSEG_OFF_ARR, 32'h0000_0100, 32'h0000_0100, TSEG_RESP_OKAY};
        rows[3] = '{TSEG_OFF_PSC, 32'h0000_0003, 32'h0000_0003, TSEG_RESP_OKAY};
        rows[4] = '{TSEG_OFF_IEN, 32'h0000_0041, 32'h0000_0041, TSEG_RESP_OKAY};
        rows[5] = '{8'h80, 32'h0000_005A, 32'h0000_0000, TSEG_RESP_SLVERR};
        ctl = '{8'h00, 8'h10, 8'h30, 8'h04, 8'h02};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        // register table
        for (int i = 0; i < 6; i++)
        begin
            logic [31:0] data;
            axi_write(rows[i].addr, rows[i].wd, resp);
            check_word(32'(resp), 32'(rows[i].resp));
            axi_read(rows[i].addr, data, resp);
            check_word(data, rows[i].rd);
            check_word(32'(resp), 32'(rows[i].resp));
        end
        $display("register table test done");
        // mid-run reset
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        check_bit(irq, 1'b0);
        rd_chk(TSEG_OFF_CMR1, 32'h0000_0000);
        rd_chk(TSEG_OFF_ARR, {16'h0, TSEG_RST_ARR});
        $display("reset test done");
        // trigger, unmasked then masked
        wr(TSEG_OFF_IEN, 32'h0000_0040);
        wr(TSEG_OFF_EGR, 32'h0000_0040);
        check_word(32'(last_evt), 32'h01);
        #1;
        check_bit(irq, 1'b1);
        rd_chk(TSEG_OFF_STATUS, 32'h0000_0040);
        rd_chk(TSEG_OFF_EGR, 32'h0000_0000);
        wr(TSEG_OFF_STATUS, 32'h0000_0000);
        #1;
        check_bit(irq, 1'b0);
        wr(TSEG_OFF_IEN, 32'h0000_0000);
        wr(TSEG_OFF_EGR, 32'h0000_0040);
        #1;
        check_bit(irq, 1'b0);
        rd_chk(TSEG_OFF_STATUS, 32'h0000_0040);
        wr(TSEG_OFF_STATUS, 32'h0000_0000);
        $display("trigger test done");
        // output channel: flag only, no capture
        wr(TSEG_OFF_CNT, 32'h0000_0055);
        wr(TSEG_OFF_EGR, 32'h0000_0002);
        check_word(32'(last_evt), 32'h02);
        rd_chk(TSEG_OFF_STATUS, 32'h0000_0002);
        rd_chk(TSEG_OFF_CCR1, 32'h0000_0000);
        wr(TSEG_OFF_STATUS, 32'h0000_0000);
        // four input channels; second capture overcaptures
        wr(TSEG_OFF_CMR1, 32'h0000_0101);
        wr(TSEG_OFF_CMR2, 32'h0000_0101);
        for (int k = 0; k < 2; k++)
        begin
            wr(TSEG_OFF_CNT, 32'h0000_0060 + k);
            wr(TSEG_OFF_EGR, 32'h0000_001E);
            check_word(32'(last_evt), 32'h1E);
            rd_chk(TSEG_OFF_STATUS, (k == 0) ? 32'h0000_001E : 32'h0000_1E1E);
            for (int c = 0; c < 4; c++)
                rd_chk(TSEG_OFF_CCR1 + 8'(4 * c), 32'h0000_0060 + k);
        end
        $display("channel test done");
        // forced update in five modes
        wr(TSEG_OFF_ARR, 32'h0000_0100);
        for (int m = 0; m < 5; m++)
        begin
            wr(TSEG_OFF_STATUS, 32'h0000_0000);
            wr(TSEG_OFF_CTRL, {24'h0, ctl[m]});
            wr(TSEG_OFF_CNT, 32'h0000_0077);
            wr(TSEG_OFF_EGR, 32'h0000_0001);
            check_word(32'(last_evt), (m == 4) ? 32'h00 : 32'h20);
            rd_chk(TSEG_OFF_STATUS, (m < 3) ? 32'h0000_0001 : 32'h0000_0000);
            rd_chk(TSEG_OFF_CNT, (m == 1) ? 32'h0000_0100 : 32'h0000_0000);
        end
        // running counter: prescaler restarts
        wr(TSEG_OFF_PSC, 32'h0000_0007);
        wr(TSEG_OFF_CTRL, 32'h0000_0001);
        repeat (13) @(posedge aclk);
        wr(TSEG_OFF_EGR, 32'h0000_0001);
        rd_chk(TSEG_OFF_CNT, 32'h0000_0000);
        rd_chk(TSEG_OFF_PSC, 32'h0000_0007);
        $display("update test done");
        finish_test();
    end
endmodule

bind tseg_top tseg_monitor u_mon (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .forced_evt
);

// ===== tseg_monitor.sv
// bus and forced-event checks for the event block
`timescale 1ns/1ns
module tseg_monitor
    import tseg_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire tseg_evt_t   forced_evt
);
    // single clock domain
    default clocking mon_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // both write channels taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // read address taken
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // read of the generate register taken
    sequence egr_read;
        rd_taken ##0 (s_axi_araddr == TSEG_OFF_EGR);
    endsequence

    chk_write_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("late write answer");
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("late read answer");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp not held");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata not held");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_evt_single: assert property (forced_evt != '0 |=> forced_evt == '0)
        else $error("event too long");
    chk_evt_at_resp: assert property (forced_evt != '0 |-> $rose(s_axi_bvalid))
        else $error("stray event");
    chk_egr_zero: assert property (egr_read |=> s_axi_rdata == 32'h0000_0000)
        else $error("generate register read not zero");
endmodule

// ===== tseg_pkg.sv
// package for the timer software event generation block
package tseg_pkg;

    // register byte offsets
    localparam logic [7:0]  TSEG_OFF_STATUS  = 8'h10;   // timer_status
    localparam logic [7:0]  TSEG_OFF_EGR     = 8'h14;   // event_generate
    localparam logic [7:0]  TSEG_OFF_CMR1    = 8'h18;   // channel12_mode
    localparam logic [7:0]  TSEG_OFF_CMR2    = 8'h1C;   // channel34_mode
    localparam logic [7:0]  TSEG_OFF_CTRL    = 8'h00;   // direction and update control
    localparam logic [7:0]  TSEG_OFF_IEN     = 8'h0C;   // interrupt mask
    localparam logic [7:0]  TSEG_OFF_CNT     = 8'h24;   // counter
    localparam logic [7:0]  TSEG_OFF_PSC     = 8'h28;   // prescale factor
    localparam logic [7:0]  TSEG_OFF_ARR     = 8'h2C;   // auto_reload_value
    localparam logic [7:0]  TSEG_OFF_CCR1    = 8'h34;   // ch1_capture_value, ch n at +4*(n-1)

    // event generate bit positions
    localparam int TSEG_BIT_UG  = 0;
    localparam int TSEG_BIT_CC1 = 1;
    localparam int TSEG_BIT_TG  = 6;

    // status bit positions
    localparam int TSEG_ST_UIF  = 0;
    localparam int TSEG_ST_CC1  = 1;
    localparam int TSEG_ST_TIF  = 6;
    localparam int TSEG_ST_OF1  = 9;
    localparam logic [31:0] TSEG_ST_MASK  = 32'h0000_1E5F;  // implemented status bits
    localparam logic [31:0] TSEG_EGR_MASK = 32'h0000_005F;  // implemented generate bits

    // control bit positions
    localparam int TSEG_CTL_CEN  = 0;
    localparam int TSEG_CTL_UPDATE_DISABLE = 1;
    localparam int TSEG_CTL_URS  = 2;
    localparam int TSEG_CTL_DIR  = 4;
    localparam int TSEG_CTL_CMS0 = 5;

    // reset values
    localparam logic [31:0] TSEG_RST_ZERO = 32'h0000_0000;
    localparam logic [15:0] TSEG_RST_ARR  = 16'hFFFF;

    // axi responses
    localparam logic [1:0] TSEG_RESP_OKAY   = 2'b00;
    localparam logic [1:0] TSEG_RESP_SLVERR = 2'b10;

    // bus slave states
    typedef enum logic [2:0] {
        TSEG_IDLE = 3'b001,
        TSEG_BUSY = 3'b010,
        TSEG_RESP = 3'b100
    } tseg_state_t;

    // forced events toward the counter core
    typedef struct packed {
        logic       update;
        logic [3:0] chan;
        logic       trigger;
    } tseg_evt_t;

endpackage

// ===== tseg_prescaler.sv
// prescaler counter with a clear from forced update
`timescale 1ns/1ns
module tseg_prescaler
    import tseg_pkg::*;
#(
    parameter int WIDTH = 16
)(
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             run,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] factor,
    output logic                  tick
);
    logic [WIDTH-1:0] cnt_reg;   // internal division count
    logic [WIDTH-1:0] cnt_next;

    // next count; the factor is never touched here
    always_comb
    begin
        cnt_next = cnt_reg;
        tick     = 1'b0;
        if (clear)
        begin
            cnt_next = '0;
        end
        else if (run)
        begin
            if (cnt_reg >= factor)
            begin
                cnt_next = '0;
                tick     = 1'b1;
            end
            else
            begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    // count register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end
endmodule

// ===== tseg_top.sv
// timer event generation register with counter, capture and status
//
// Behaviour
// R01: trigger generate bit makes event, self-clears
// R02: trigger event sets flag, irq when enabled
// R03: ch1 generate bit makes event, self-clears
// R04: output channel: forced event only sets flag
// R05: input channel: counter captured, flag set
// R06: flag already set on capture sets overcapture
// R07: channels 2 to 4 behave like channel 1
// R08: update generate reinitialises counter, self-clears
// R09: forced update clears prescaler count only
// R10: load zero up/centre, reload value down
// R11: channel 1/2 mode register resets to zero
// R12: update flag set unless source-select or disable
// R13: reserved and generate bits read as zero; control register returns its reserved bits as written
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ns
module tseg_top
    import tseg_pkg::*;
#(
    parameter int CW = 16                    // counter width
)(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [7:0]   s_axi_awaddr,
    input  wire logic         s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire logic [31:0]  s_axi_wdata,
    input  wire logic [3:0]   s_axi_wstrb,
    input  wire logic         s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire logic         s_axi_bready,
    input  wire logic [7:0]   s_axi_araddr,
    input  wire logic         s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire logic         s_axi_rready,
    output tseg_evt_t         forced_evt,
    output logic              irq
);
    // byte-enable merge used by every writable register except the generate register
    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        return r;
    endfunction

    // channel is input when its selection field is non-zero
    function automatic logic is_input(input logic [31:0] cmr, input int hi);
        return (hi != 0) ? (cmr[9:8] != 2'b00) : (cmr[1:0] != 2'b00);
    endfunction

    tseg_state_t       wst_reg, wst_next;      // write path state
    logic [7:0]        wad_reg, wad_next;      // latched write address
    logic              awh_reg, awh_next;      // address held
    logic [31:0]       wd_reg, wd_next;        // latched write data
    logic [3:0]        ws_reg, ws_next;        // latched strobes
    logic              wh_reg, wh_next;        // data held
    logic [1:0]        bresp_reg, bresp_next;
    tseg_state_t       rst_reg, rst_next;      // read path state
    logic [31:0]       rd_reg, rd_next;
    logic [1:0]        rresp_reg, rresp_next;

    logic [31:0]       ctrl_reg, ctrl_next;    // cen, update_disable, urs, dir, cms
    logic [31:0]       ien_reg, ien_next;      // interrupt mask
    logic [31:0]       st_reg, st_next;        // timer_status
    logic [31:0]       cmr1_reg, cmr1_next;    // channel12_mode
    logic [31:0]       cmr2_reg, cmr2_next;    // channel34_mode
    logic [CW-1:0]     cnt_reg, cnt_next;
    logic [CW-1:0]     psc_reg, psc_next;
    logic [CW-1:0]     arr_reg, arr_next;
    logic [CW-1:0]     ccr_reg [4];
    logic [CW-1:0]     ccr_next [4];
    tseg_evt_t         evt_reg, evt_next;      // pulse of forced events

    logic              do_write;               // write commits this cycle
    logic [31:0]       egr_wr;                 // generate bits written
    logic              tick;                   // prescaler output

    assign do_write = (wst_reg == TSEG_BUSY);
    // generate bits exist only for one cycle of a write; reserved ignored
    assign egr_wr   = (do_write && wad_reg == TSEG_OFF_EGR && ws_reg[0]) ? (wd_reg & TSEG_EGR_MASK) : '0; // R01 R03 R08 R13

    // prescaler counter, cleared by forced update
    tseg_prescaler #(.WIDTH(CW)) u_psc (
        .aclk    (aclk),
        .aresetn (aresetn),
        .run     (ctrl_reg[TSEG_CTL_CEN]),
        .clear   (egr_wr[TSEG_BIT_UG]),       // R09
        .factor  (psc_reg),
        .tick    (tick)
    );

    // axi write channel: take address and data in either order
    always_comb
    begin
        wst_next   = wst_reg;
        wad_next   = wad_reg;
        awh_next   = awh_reg;
        wd_next    = wd_reg;
        ws_next    = ws_reg;
        wh_next    = wh_reg;
        bresp_next = bresp_reg;
        case (wst_reg)
            TSEG_IDLE:
            begin
                if (s_axi_awvalid && !awh_reg)
                begin
                    wad_next = s_axi_awaddr;
                    awh_next = 1'b1;
                end
                if (s_axi_wvalid && !wh_reg)
                begin
                    wd_next = s_axi_wdata;
                    ws_next = s_axi_wstrb;
                    wh_next = 1'b1;
                end
                if (awh_next && wh_next)
                    wst_next = TSEG_BUSY;
            end
            TSEG_BUSY:
            begin
                // commit cycle; unmapped addresses answer slave error
                case (wad_reg)
                    TSEG_OFF_CTRL, TSEG_OFF_IEN, TSEG_OFF_STATUS, TSEG_OFF_EGR, TSEG_OFF_CMR1,
                    TSEG_OFF_CMR2, TSEG_OFF_CNT, TSEG_OFF_PSC, TSEG_OFF_ARR, TSEG_OFF_CCR1,
                    TSEG_OFF_CCR1 + 8'h04, TSEG_OFF_CCR1 + 8'h08, TSEG_OFF_CCR1 + 8'h0C:
                        bresp_next = TSEG_RESP_OKAY;
                    default:
                        bresp_next = TSEG_RESP_SLVERR;
                endcase
                awh_next = 1'b0;
                wh_next  = 1'b0;
                wst_next = TSEG_RESP;
            end
            TSEG_RESP:
            begin
                if (s_axi_bready)
                    wst_next = TSEG_IDLE;
            end
            default:
                wst_next = TSEG_IDLE;
        endcase
    end

    assign s_axi_awready = (wst_reg == TSEG_IDLE) && !awh_reg;
    assign s_axi_wready  = (wst_reg == TSEG_IDLE) && !wh_reg;
    assign s_axi_bvalid  = (wst_reg == TSEG_RESP);
    assign s_axi_bresp   = bresp_reg;

    // axi read channel, one cycle to data
    always_comb
    begin
        rst_next   = rst_reg;
        rd_next    = rd_reg;
        rresp_next = rresp_reg;
        case (rst_reg)
            TSEG_IDLE:
            begin
                if (s_axi_arvalid)
                begin
                    rst_next   = TSEG_RESP;
                    rresp_next = TSEG_RESP_OKAY;
                    case (s_axi_araddr)
                        TSEG_OFF_CTRL:         rd_next = ctrl_reg;
                        TSEG_OFF_IEN:          rd_next = ien_reg;
                        TSEG_OFF_STATUS:       rd_next = st_reg;
                        TSEG_OFF_EGR:          rd_next = '0;                  // R13
                        TSEG_OFF_CMR1:         rd_next = cmr1_reg;
                        TSEG_OFF_CMR2:         rd_next = cmr2_reg;
                        TSEG_OFF_CNT:          rd_next = 32'(cnt_reg);
                        TSEG_OFF_PSC:          rd_next = 32'(psc_reg);
                        TSEG_OFF_ARR:          rd_next = 32'(arr_reg);
                        TSEG_OFF_CCR1:         rd_next = 32'(ccr_reg[0]);
                        TSEG_OFF_CCR1 + 8'h04: rd_next = 32'(ccr_reg[1]);
                        TSEG_OFF_CCR1 + 8'h08: rd_next = 32'(ccr_reg[2]);
                        TSEG_OFF_CCR1 + 8'h0C: rd_next = 32'(ccr_reg[3]);
                        default:
                        begin
                            rd_next    = '0;
                            rresp_next = TSEG_RESP_SLVERR;
                        end
                    endcase
                end
            end
            TSEG_RESP:
            begin
                if (s_axi_rready)
                    rst_next = TSEG_IDLE;
            end
            default:
                rst_next = TSEG_IDLE;
        endcase
    end

    assign s_axi_arready = (rst_reg == TSEG_IDLE);
    assign s_axi_rvalid  = (rst_reg == TSEG_RESP);
    assign s_axi_rdata   = rd_reg;
    assign s_axi_rresp   = rresp_reg;

    // timer state: registers, counter, forced events and flags
    always_comb
    begin
        logic [31:0] clr;
        logic        sw_load;
        clr       = '0;
        sw_load   = 1'b0;
        ctrl_next = ctrl_reg;
        ien_next  = ien_reg;
        cmr1_next = cmr1_reg;
        cmr2_next = cmr2_reg;
        psc_next  = psc_reg;
        arr_next  = arr_reg;
        cnt_next  = cnt_reg;
        for (int c = 0; c < 4; c++)
            ccr_next[c] = ccr_reg[c];
        if (do_write)
        begin
            case (wad_reg)
                TSEG_OFF_CTRL:   ctrl_next = wmerge(ctrl_reg, wd_reg, ws_reg);
                TSEG_OFF_IEN:    ien_next  = wmerge(ien_reg, wd_reg, ws_reg) & TSEG_ST_MASK;
                TSEG_OFF_STATUS: clr       = ~wmerge(~TSEG_RST_ZERO, wd_reg, ws_reg); // zero clears
                TSEG_OFF_CMR1:   cmr1_next = wmerge(cmr1_reg, wd_reg, ws_reg) & 32'h0000_FFFF;
                TSEG_OFF_CMR2:   cmr2_next = wmerge(cmr2_reg, wd_reg, ws_reg) & 32'h0000_FFFF;
                TSEG_OFF_PSC:    psc_next  = CW'(wmerge(32'(psc_reg), wd_reg, ws_reg));
                TSEG_OFF_ARR:    arr_next  = CW'(wmerge(32'(arr_reg), wd_reg, ws_reg));
                TSEG_OFF_CNT:
                begin
                    cnt_next = CW'(wmerge(32'(cnt_reg), wd_reg, ws_reg));
                    sw_load  = 1'b1;
                end
                TSEG_OFF_CCR1:         ccr_next[0] = CW'(wmerge(32'(ccr_reg[0]), wd_reg, ws_reg));
                TSEG_OFF_CCR1 + 8'h04: ccr_next[1] = CW'(wmerge(32'(ccr_reg[1]), wd_reg, ws_reg));
                TSEG_OFF_CCR1 + 8'h08: ccr_next[2] = CW'(wmerge(32'(ccr_reg[2]), wd_reg, ws_reg));
                TSEG_OFF_CCR1 + 8'h0C: ccr_next[3] = CW'(wmerge(32'(ccr_reg[3]), wd_reg, ws_reg));
                default:               ;
            endcase
        end
        // free counting on prescaler tick, simple up or down
        if (!sw_load && tick)
            cnt_next = ctrl_reg[TSEG_CTL_DIR] ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
        // forced update wins over counting; centre mode counts as up
        if (egr_wr[TSEG_BIT_UG])                                            // R08
        begin
            if (ctrl_reg[TSEG_CTL_DIR] && ctrl_reg[TSEG_CTL_CMS0 +: 2] == 2'b00)
                cnt_next = arr_reg;                                         // R10
            else
                cnt_next = '0;                                              // R10
        end
        // flags: set wins over a same-cycle software clear
        st_next = st_reg & ~clr;
        if (egr_wr[TSEG_BIT_UG] && !ctrl_reg[TSEG_CTL_URS] && !ctrl_reg[TSEG_CTL_UPDATE_DISABLE])
            st_next[TSEG_ST_UIF] = 1'b1;                                    // R12
        if (egr_wr[TSEG_BIT_TG])
            st_next[TSEG_ST_TIF] = 1'b1;                                    // R02
        for (int c = 0; c < 4; c++)
        begin
            if (egr_wr[TSEG_BIT_CC1 + c])                                   // R03 R07
            begin
                st_next[TSEG_ST_CC1 + c] = 1'b1;                            // R04
                if (is_input(c < 2 ? cmr1_reg : cmr2_reg, c % 2))
                begin
                    ccr_next[c] = cnt_reg;                                  // R05
                    if (st_reg[TSEG_ST_CC1 + c])
                        st_next[TSEG_ST_OF1 + c] = 1'b1;                    // R06
                end
            end
        end
        st_next = st_next & TSEG_ST_MASK;
        // one-cycle pulses to the counter core and dma logic
        evt_next.update  = egr_wr[TSEG_BIT_UG] && !ctrl_reg[TSEG_CTL_UPDATE_DISABLE];
        evt_next.chan    = egr_wr[TSEG_BIT_CC1 +: 4];
        evt_next.trigger = egr_wr[TSEG_BIT_TG];                             // R01
    end

    assign forced_evt = evt_reg;
    assign irq        = |(st_reg & ien_reg);                                // R02 R04

    // registers only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wst_reg   <= TSEG_IDLE;
            wad_reg   <= '0;
            awh_reg   <= 1'b0;
            wd_reg    <= '0;
            ws_reg    <= '0;
            wh_reg    <= 1'b0;
            bresp_reg <= TSEG_RESP_OKAY;
            rst_reg   <= TSEG_IDLE;
            rd_reg    <= '0;
            rresp_reg <= TSEG_RESP_OKAY;
            ctrl_reg  <= TSEG_RST_ZERO;
            ien_reg   <= TSEG_RST_ZERO;
            st_reg    <= TSEG_RST_ZERO;
            cmr1_reg  <= TSEG_RST_ZERO;                                     // R11
            cmr2_reg  <= TSEG_RST_ZERO;
            cnt_reg   <= '0;
            psc_reg   <= '0;
            arr_reg   <= CW'(TSEG_RST_ARR);
            for (int c = 0; c < 4; c++)
                ccr_reg[c] <= '0;
            evt_reg   <= '0;
        end
        else
        begin
            wst_reg   <= wst_next;
            wad_reg   <= wad_next;
            awh_reg   <= awh_next;
            wd_reg    <= wd_next;
            ws_reg    <= ws_next;
            wh_reg    <= wh_next;
            bresp_reg <= bresp_next;
            rst_reg   <= rst_next;
            rd_reg    <= rd_next;
            rresp_reg <= rresp_next;
            ctrl_reg  <= ctrl_next;
            ien_reg   <= ien_next;
            st_reg    <= st_next;
            cmr1_reg  <= cmr1_next;
            cmr2_reg  <= cmr2_next;
            cnt_reg   <= cnt_next;
            psc_reg   <= psc_next;
            arr_reg   <= arr_next;
            for (int c = 0; c < 4; c++)
                ccr_reg[c] <= ccr_next[c];
            evt_reg   <= evt_next;
        end
    end
endmodule
